// ===== common/gwoc_consts.svh
`ifndef GWOC_CONSTS_SVH
`define GWOC_CONSTS_SVH

`define GWOC_ADDR_W          6
`define GWOC_REG_CTRL        6'h00
`define GWOC_REG_PHASE       6'h04
`define GWOC_REG_PERIOD      6'h08
`define GWOC_REG_IDLE        6'h0C
`define GWOC_REG_STATUS      6'h10
`define GWOC_REG_CMD         6'h14
`define GWOC_CTRL_RESET      32'h00000000
`define GWOC_PERIOD_RESET    32'h00000064
`define GWOC_PHASE_W         16
`define GWOC_HALF_TURN       16'h8000
`define GWOC_PHASE_STEP      16'h0100
`define GWOC_FULL_SCALE      16'h7FFF
`define GWOC_RESP_OKAY       2'b00
`define GWOC_RESP_SLVERR     2'b10
`define GWOC_CMD_TRIG_BIT    0
`define GWOC_CMD_SOFT_BIT    1
`define GWOC_CMD_HARD_BIT    2
`define GWOC_SYNC_PULSE_LEN  8'h04

`endif

// ===== common/gwoc_pkg.sv
package gwoc_pkg;

    typedef enum logic [1:0] {
        GWOC_SRC_INT = 2'h0,
        GWOC_SRC_EXT = 2'h1
    } gwoc_src_t;

    typedef enum logic [1:0] {
        GWOC_POL_OFF = 2'h0,
        GWOC_POL_POS = 2'h1,
        GWOC_POL_NEG = 2'h2
    } gwoc_pol_t;

    typedef enum logic [1:0] {
        GWOC_BM_GATE = 2'h0,
        GWOC_BM_TRIG = 2'h1
    } gwoc_bm_t;

    typedef enum logic [2:0] {
        GWOC_AUX_OFF  = 3'h0,
        GWOC_AUX_SYNC = 3'h1,
        GWOC_AUX_BRST = 3'h2,
        GWOC_AUX_MSYN = 3'h3,
        GWOC_AUX_WAVE = 3'h4
    } gwoc_aux_t;

    typedef enum logic [2:0] {
        GWOC_ST_IDLE = 3'b001,
        GWOC_ST_RUN  = 3'b010,
        GWOC_ST_STOP = 3'b100
    } gwoc_state_t;

    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } gwoc_wreq_t;

    typedef struct packed {
        logic       wave_is_dc;
        logic       wave_is_noise;
        logic       mod_on;
        logic       mod_internal;
    } gwoc_wave_cfg_t;

endpackage

// ===== hw/gwoc_top.sv
// Behaviour
// RULE1 - Gate mode runs only while gate on
// RULE2 - Whole-cycle unit halts at start/stop angle
// RULE3 - Half unit halts at angle or +180
// RULE4 - Internal timer gate is 50% square
// RULE5 - Manual key forces gate on
// RULE6 - Gate mode ignores programmed trigger delay
// RULE7 - DC waveform disables gate oscillation
// RULE8 - Noise follows gate exactly, no boundary
// RULE9 - Noise always holds idle percentage level
// RULE10 - Burst flag low running, high stopped
// RULE11 - Reference pulse rises at reference phase
// RULE12 - Aux output off holds low
// RULE13 - Aux choices depend on modulation mode
// RULE14 - Idle level from angle or percentage
// RULE15 - Triggered lamp lit while gate on
// RULE16 - Remote emulation: trigger burst, inf, zero delay
// RULE17 - Soft close to boundary, hard close immediately
// RULE18 - Remote trigger accepted from any source
// RULE19 - Rewriting trigger burst stops immediately
// RULE20 - Outside gate polarity, off disables
// RULE21 - No direct remote gate level
// RULE22 - Outside gate two-stage synchronised
// RULE23 - Outside input treated as logic level
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "gwoc_consts.svh"

module gwoc_top (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [5:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [5:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire gwoc_pkg::gwoc_wave_cfg_t wave_cfg,
    input  wire logic                   ext_gate_in,
    input  wire logic                   manual_key,
    input  wire logic                   aux_waveform_bit,
    input  wire logic                   mod_marker_bit,
    input  wire logic                   mod_wave_bit,
    output logic                        osc_enable,
    output logic [15:0]                 osc_phase,
    output logic                        hold_idle,
    output logic [15:0]                 idle_level,
    output logic                        sync_sub_out,
    output logic                        triggered_lamp
);
    import gwoc_pkg::*;

    // Control register fields.
    logic [31:0] ctrl;
    logic [15:0] start_phase;
    logic [31:0] trig_period;
    logic [15:0] idle_pct;
    logic [31:0] trig_delay;
    wire logic        burst_enable          = ctrl[0];
    wire gwoc_bm_t    burst_behaviour_select = gwoc_bm_t'(ctrl[2:1]);
    wire logic        halt_granularity      = ctrl[3];
    wire logic        idle_level_override   = ctrl[4];
    wire gwoc_src_t   gate_src              = gwoc_src_t'(ctrl[6:5]);
    wire gwoc_pol_t   ext_pol               = gwoc_pol_t'(ctrl[8:7]);
    wire gwoc_aux_t   auxiliary_output_select = gwoc_aux_t'(ctrl[11:9]);

    // AXI write path: address and data may arrive in either order.
    logic        aw_held;
    logic        w_held;
    gwoc_wreq_t  wreq;
    wire logic   aw_take = s_axi_awvalid && s_axi_awready;
    wire logic   w_take  = s_axi_wvalid && s_axi_wready;
    wire logic   do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic   wr_ctrl  = do_write && (wreq.addr == `GWOC_REG_CTRL);
    wire logic   wr_phase = do_write && (wreq.addr == `GWOC_REG_PHASE);
    wire logic   wr_per   = do_write && (wreq.addr == `GWOC_REG_PERIOD);
    wire logic   wr_idle  = do_write && (wreq.addr == `GWOC_REG_IDLE);
    wire logic   wr_cmd   = do_write && (wreq.addr == `GWOC_REG_CMD);
    wire logic   wr_stat  = do_write && (wreq.addr == `GWOC_REG_STATUS);
    wire logic   wr_ok    = wr_ctrl || wr_phase || wr_per || wr_idle || wr_cmd || wr_stat;
    wire logic [31:0] next_ctrl;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign next_ctrl[gi*8 +: 8] = wreq.strb[gi] ? wreq.data[gi*8 +: 8] : ctrl[gi*8 +: 8];
        end
    endgenerate
    wire logic cmd_trig = wr_cmd && wreq.strb[0] && wreq.data[`GWOC_CMD_TRIG_BIT];
    wire logic cmd_soft = wr_cmd && wreq.strb[0] && wreq.data[`GWOC_CMD_SOFT_BIT];
    wire logic cmd_hard = wr_cmd && wreq.strb[0] && wreq.data[`GWOC_CMD_HARD_BIT];
    // A rewrite of trigger-burst mode while a burst runs acts as a hard stop.
    wire logic rewrite_trig = wr_ctrl && wreq.strb[0] &&
                              (gwoc_bm_t'(wreq.data[2:1]) == GWOC_BM_TRIG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wreq          <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GWOC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !aw_take;
            s_axi_wready  <= !w_held && !w_take;
            if (aw_take) begin
                aw_held   <= 1'b1;
                wreq.addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held    <= 1'b1;
                wreq.data <= s_axi_wdata;
                wreq.strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `GWOC_RESP_OKAY : `GWOC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register storage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl        <= `GWOC_CTRL_RESET;
            start_phase <= '0;
            trig_period <= `GWOC_PERIOD_RESET;
            idle_pct    <= '0;
            trig_delay  <= '0;
        end else begin
            if (wr_ctrl) ctrl <= next_ctrl;
            if (wr_phase) start_phase <= wreq.data[15:0];
            if (wr_per) trig_period <= wreq.data;
            if (wr_idle) idle_pct <= wreq.data[15:0];
            if (wr_stat) trig_delay <= wreq.data;
        end
    end

    // Outside gate: two-stage synchroniser, then polarity.
    logic ext_s1;
    logic ext_s2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
        end else begin
            ext_s1 <= ext_gate_in; // RULE22
            ext_s2 <= ext_s1;      // RULE22
        end
    end
    wire logic ext_gate = (ext_pol == GWOC_POL_POS) ? ext_s2 :          // RULE20 RULE23
                          (ext_pol == GWOC_POL_NEG) ? !ext_s2 : 1'b0;

    // Internal trigger timer: toggles each half period for 50% duty.
    logic [31:0] tmr_cnt;
    logic        int_gate;
    wire logic [31:0] half_per = {1'b0, trig_period[31:1]};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_cnt  <= '0;
            int_gate <= 1'b0;
        end else if (tmr_cnt + 32'h1 >= half_per) begin
            tmr_cnt  <= '0;
            int_gate <= !int_gate; // RULE4
        end else begin
            tmr_cnt <= tmr_cnt + 32'h1;
        end
    end

    // Gate comes only from timer, outside input or key; no remote gate level exists.
    wire logic src_gate = (gate_src == GWOC_SRC_INT) ? int_gate : ext_gate; // RULE21
    wire logic gate_on  = src_gate || manual_key;                           // RULE5
    wire logic gate_mode = burst_enable && (burst_behaviour_select == GWOC_BM_GATE);
    wire logic trig_mode = burst_enable && (burst_behaviour_select == GWOC_BM_TRIG);

    // Oscillation sequencer. Gate mode starts with no delay beyond one cycle,
    // since the programmed trigger delay is never consulted here.
    gwoc_state_t state;
    gwoc_state_t next_state;
    wire logic [15:0] next_phase = osc_phase + `GWOC_PHASE_STEP;
    wire logic [15:0] half_phase = start_phase + `GWOC_HALF_TURN;
    wire logic cross_start = (osc_phase - start_phase) > (next_phase - start_phase);
    wire logic cross_half  = (osc_phase - half_phase) > (next_phase - half_phase);
    wire logic at_boundary = cross_start || (halt_granularity && cross_half); // RULE2 RULE3
    wire logic run_req = (gate_mode && gate_on) || (trig_mode && cmd_trig);   // RULE6 RULE18 RULE16
    wire logic hard_stop = !burst_enable || wave_cfg.wave_is_dc ||            // RULE7
                           (wave_cfg.wave_is_noise && gate_mode && !gate_on) || // RULE8
                           cmd_hard || (trig_mode && rewrite_trig);           // RULE17 RULE19
    logic soft_stop_req;

    always_comb begin
        next_state = state;
        case (state)
            GWOC_ST_IDLE: begin
                if (run_req && !hard_stop) next_state = GWOC_ST_RUN;
            end
            GWOC_ST_RUN: begin
                if (hard_stop) next_state = GWOC_ST_IDLE;
                else if ((gate_mode && !gate_on) || cmd_soft || soft_stop_req)
                    next_state = GWOC_ST_STOP; // RULE1 RULE17
            end
            GWOC_ST_STOP: begin
                if (hard_stop || at_boundary) next_state = GWOC_ST_IDLE; // RULE2 RULE3
            end
            default: next_state = GWOC_ST_IDLE;
        endcase
    end

    wire logic running = (state != GWOC_ST_IDLE);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state         <= GWOC_ST_IDLE;
            osc_phase     <= '0;
            soft_stop_req <= 1'b0;
        end else begin
            state         <= next_state;
            soft_stop_req <= cmd_soft && (state == GWOC_ST_IDLE);
            if (next_state == GWOC_ST_IDLE)
                osc_phase <= start_phase; // RULE3 RULE14
            else if (running)
                osc_phase <= next_phase;
        end
    end

    // Idle level and control outputs.
    wire logic use_pct = idle_level_override || wave_cfg.wave_is_noise; // RULE9 RULE14
    logic [7:0] sync_cnt;
    wire logic ref_hit = running && cross_start; // RULE11
    wire logic mod_int = wave_cfg.mod_on && wave_cfg.mod_internal;
    logic next_aux;
    always_comb begin
        next_aux = 1'b0;
        case (auxiliary_output_select)
            GWOC_AUX_SYNC: next_aux = ref_hit || (sync_cnt != 8'h00);                // RULE11
            // Follows next_state so the flag changes on the same edge as osc_enable.
            GWOC_AUX_BRST: next_aux = (next_state == GWOC_ST_IDLE);                  // RULE10
            GWOC_AUX_MSYN: next_aux = mod_int && mod_marker_bit;                     // RULE13
            GWOC_AUX_WAVE: next_aux = mod_int ? mod_wave_bit : aux_waveform_bit;     // RULE13
            default:       next_aux = 1'b0;                                          // RULE12
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_enable     <= 1'b0;
            hold_idle      <= 1'b1;
            idle_level     <= '0;
            sync_sub_out   <= 1'b0;
            triggered_lamp <= 1'b0;
            sync_cnt       <= '0;
        end else begin
            osc_enable     <= (next_state != GWOC_ST_IDLE);  // RULE1
            hold_idle      <= (next_state == GWOC_ST_IDLE);
            idle_level     <= use_pct ? idle_pct : 16'h0000; // RULE9 RULE14
            sync_sub_out   <= next_aux;
            triggered_lamp <= gate_mode && gate_on;          // RULE15
            if (ref_hit) sync_cnt <= `GWOC_SYNC_PULSE_LEN;
            else if (sync_cnt != 8'h00) sync_cnt <= sync_cnt - 8'h01;
        end
    end

    // AXI read path.
    wire logic [31:0] status_word = {26'h0, state, running, gate_on, 1'b0};
    wire logic [31:0] rd_mux =
        (s_axi_araddr == `GWOC_REG_CTRL)   ? ctrl :
        (s_axi_araddr == `GWOC_REG_PHASE)  ? {16'h0, start_phase} :
        (s_axi_araddr == `GWOC_REG_PERIOD) ? trig_period :
        (s_axi_araddr == `GWOC_REG_IDLE)   ? {16'h0, idle_pct} :
        (s_axi_araddr == `GWOC_REG_STATUS) ? status_word : 32'h0;
    wire logic rd_ok = (s_axi_araddr == `GWOC_REG_CTRL) || (s_axi_araddr == `GWOC_REG_PHASE) ||
                       (s_axi_araddr == `GWOC_REG_PERIOD) || (s_axi_araddr == `GWOC_REG_IDLE) ||
                       (s_axi_araddr == `GWOC_REG_STATUS) || (s_axi_araddr == `GWOC_REG_CMD);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `GWOC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? `GWOC_RESP_OKAY : `GWOC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ===== tb/gwoc_monitor.sv
`timescale 1ns/1ps
`include "gwoc_consts.svh"
module gwoc_monitor (
    input wire logic                     aclk,
    input wire logic                     aresetn,
    input wire logic                     s_axi_awvalid,
    input wire logic                     s_axi_awready,
    input wire logic                     s_axi_wvalid,
    input wire logic                     s_axi_wready,
    input wire logic [1:0]               s_axi_bresp,
    input wire logic                     s_axi_bvalid,
    input wire logic                     s_axi_bready,
    input wire logic                     s_axi_arvalid,
    input wire logic                     s_axi_arready,
    input wire logic [31:0]              s_axi_rdata,
    input wire logic [1:0]               s_axi_rresp,
    input wire logic                     s_axi_rvalid,
    input wire logic                     s_axi_rready,
    input wire gwoc_pkg::gwoc_wave_cfg_t wave_cfg,
    input wire logic                     osc_enable,
    input wire logic [15:0]              osc_phase,
    input wire logic                     hold_idle
);
    import gwoc_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Noise has no phase, so the step relation is checked for periodic waveforms only; osc_phase still steps while noise runs.
    sequence phase_running;
        osc_enable && !wave_cfg.wave_is_noise ##1 osc_enable && !wave_cfg.wave_is_noise;
    endsequence
    a_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == `GWOC_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
        else $error("refused read carries data");
    a_run_not_idle: assert property (osc_enable |-> !hold_idle)
        else $error("idle hold while running");
    a_phase_step: assert property (phase_running |-> osc_phase == $past(osc_phase) + `GWOC_PHASE_STEP)
        else $error("phase step wrong");
    a_dc_blocks: assert property (wave_cfg.wave_is_dc [*3] |-> !osc_enable)
        else $error("dc waveform oscillates");
endmodule

// ===== tb/gwoc_gate_src.sv
`timescale 1ns/1ps
module gwoc_gate_src (
    input  wire logic aclk,
    input  wire logic gate_req,
    output logic      ext_gate_in
);
    // One register stage stands for the delay of the outside source and its cable.
    always @(posedge aclk) begin
        ext_gate_in <= gate_req;
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`include "gwoc_consts.svh"
module testbench;
    import gwoc_pkg::*;
    logic           aclk = 1'b0;
    logic           aresetn = 1'b0;
    logic [5:0]     s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0]    s_axi_wdata = 32'h00000000, s_axi_rdata, last_data;
    logic [3:0]     s_axi_wstrb = 4'hF;
    logic           s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic           s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]     s_axi_bresp, s_axi_rresp, last_resp;
    gwoc_wave_cfg_t wave_cfg = 4'h0;
    logic           ext_gate_in, gate_req = 1'b0, manual_key = 1'b0;
    logic           aux_waveform_bit = 1'b0, mod_marker_bit = 1'b0, mod_wave_bit = 1'b0;
    logic           osc_enable, hold_idle, sync_sub_out, triggered_lamp;
    logic [15:0]    osc_phase, idle_level;
    int             num_errors = 0, tests_run = 0, cycles = 0;

    gwoc_top uut (.*);
    gwoc_gate_src src (.aclk(aclk), .gate_req(gate_req), .ext_gate_in(ext_gate_in));

    always #12.5 aclk = ~aclk;

    task automatic check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [5:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        last_resp = s_axi_rresp;
        last_data = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Returns cycles waited and the last phase seen while still running.
    task automatic wait_en(input logic v, output int n, output logic [15:0] p);
        n = 0;
        p = osc_phase;
        while (osc_enable !== v && n < 3000) begin
            if (osc_enable === 1'b1) p = osc_phase;
            @(posedge aclk);
            n++;
        end
        check(osc_enable === v, "oscillation state");
    endtask

    function automatic logic at_stop(input logic [15:0] p, input logic [15:0] s, input logic half);
        logic [15:0] m;
        m = half ? 16'h7FFF : 16'hFFFF;
        return ((p & m) == (s & m)) || (((p + `GWOC_PHASE_STEP) & m) == (s & m));
    endfunction

    task automatic t_reset;
        check(hold_idle === 1'b1 && osc_enable === 1'b0, "reset outputs");
        check(sync_sub_out === 1'b0, "aux off level");
        axi_read(`GWOC_REG_CTRL);
        check(last_data === `GWOC_CTRL_RESET, "ctrl reset");
        axi_read(`GWOC_REG_PERIOD);
        check(last_data === `GWOC_PERIOD_RESET, "period reset");
        axi_read(6'h18);
        check(last_resp === `GWOC_RESP_SLVERR && last_data === 32'h00000000, "unmapped read");
        axi_write(6'h1C, 32'h00000001);
        check(last_resp === `GWOC_RESP_SLVERR, "unmapped write");
        $display("test reset done");
    endtask

    task automatic t_manual(input logic half, input logic [15:0] s, input logic ovr);
        int n;
        logic [15:0] p;
        axi_write(`GWOC_REG_PHASE, {16'h0000, s});
        axi_write(`GWOC_REG_IDLE, 32'h00001234);
        axi_write(`GWOC_REG_CTRL, 32'h00000421 | {27'h0000000, ovr, half, 3'h0});
        manual_key <= 1'b1;
        wait_en(1'b1, n, p);
        check(n <= 6, "gate start delay");
        check(triggered_lamp === 1'b1 && sync_sub_out === 1'b0, "running flags");
        repeat (150) @(posedge aclk);
        manual_key <= 1'b0;
        wait_en(1'b0, n, p);
        check(at_stop(p, s, half), "stop boundary");
        repeat (3) @(posedge aclk);
        check(osc_phase === s && hold_idle === 1'b1, "idle phase");
        check(sync_sub_out === 1'b1 && triggered_lamp === 1'b0, "stopped flags");
        check(idle_level === (ovr ? 16'h1234 : 16'h0000), "idle level");
        $display("test manual gate done");
    endtask

    task automatic t_ext;
        gwoc_pol_t pols[3] = '{GWOC_POL_POS, GWOC_POL_NEG, GWOC_POL_OFF};
        int n;
        logic [15:0] p;
        foreach (pols[i]) begin
            // Park the input at its idle level with polarity off, so the polarity change makes no edge.
            axi_write(`GWOC_REG_CTRL, 32'h00000021);
            gate_req <= (pols[i] == GWOC_POL_NEG);
            repeat (6) @(posedge aclk);
            axi_write(`GWOC_REG_CTRL, 32'h00000021 | {23'h000000, pols[i], 7'h00});
            gate_req <= (pols[i] != GWOC_POL_NEG);
            repeat (2) @(posedge aclk);
            check(osc_enable === 1'b0, "synchroniser delay");
            repeat (6) @(posedge aclk);
            check(osc_enable === (pols[i] != GWOC_POL_OFF), "outside gate polarity");
            gate_req <= (pols[i] == GWOC_POL_NEG);
            wait_en(1'b0, n, p);
        end
        $display("test outside gate done");
    endtask

    task automatic t_int;
        int hi, lo, n;
        logic [15:0] p;
        hi = 0;
        lo = 0;
        axi_write(`GWOC_REG_PERIOD, 32'h00000040);
        axi_write(`GWOC_REG_CTRL, 32'h00000001);
        while (triggered_lamp !== 1'b0) @(posedge aclk);
        while (triggered_lamp !== 1'b1) @(posedge aclk);
        for (; triggered_lamp === 1'b1; hi++) @(posedge aclk);
        for (; triggered_lamp === 1'b0; lo++) @(posedge aclk);
        check(hi == 32 && lo == 32, "timer gate duty");
        axi_write(`GWOC_REG_CTRL, 32'h00000021);
        wait_en(1'b0, n, p);
        $display("test timer gate done");
    endtask

    task automatic t_noise;
        int n1, n2;
        logic [15:0] p;
        wave_cfg <= 4'h4;
        axi_write(`GWOC_REG_IDLE, 32'h00001234);
        axi_write(`GWOC_REG_STATUS, 32'h0000FFFF);
        axi_write(`GWOC_REG_CTRL, 32'h00000021);
        check(idle_level === 16'h1234, "noise idle level");
        manual_key <= 1'b1;
        wait_en(1'b1, n1, p);
        repeat (37) @(posedge aclk);
        manual_key <= 1'b0;
        wait_en(1'b0, n2, p);
        check(n1 <= 6 && n2 == n1, "noise follows gate");
        wave_cfg <= 4'h8;
        manual_key <= 1'b1;
        repeat (20) @(posedge aclk);
        check(osc_enable === 1'b0, "dc refused");
        manual_key <= 1'b0;
        wave_cfg <= 4'h0;
        @(posedge aclk);
        $display("test noise and dc done");
    endtask

    task automatic t_remote;
        int n;
        logic [15:0] p;
        axi_write(`GWOC_REG_PHASE, 32'h00002000);
        axi_write(`GWOC_REG_STATUS, 32'h00000000);
        for (int k = 0; k < 3; k++) begin
            axi_write(`GWOC_REG_CTRL, 32'h00000023);
            axi_write(`GWOC_REG_CMD, 32'h00000001);
            wait_en(1'b1, n, p);
            repeat (90) @(posedge aclk);
            if (k < 2) axi_write(`GWOC_REG_CMD, 32'h00000002 << k);
            else axi_write(`GWOC_REG_CTRL, 32'h00000023);
            wait_en(1'b0, n, p);
            check(k == 0 ? at_stop(p, 16'h2000, 1'b0) : n <= 3, "remote close");
        end
        $display("test remote emulation done");
    endtask

    task automatic t_aux;
        // Entry fields: waveform config, aux select, aux/marker/mod bits, expected output.
        logic [10:0] tbl[6] = '{11'h049, 11'h1C3, 11'h1B5, 11'h1BA, 11'h00E, 11'h042};
        int n;
        logic prev;
        logic [15:0] p;
        foreach (tbl[i]) begin
            wave_cfg <= tbl[i][10:7];
            {aux_waveform_bit, mod_marker_bit, mod_wave_bit} <= tbl[i][3:1];
            axi_write(`GWOC_REG_CTRL, {20'h00000, tbl[i][6:4], 9'h021});
            repeat (3) @(posedge aclk);
            check(sync_sub_out === tbl[i][0], "aux routing");
        end
        wave_cfg <= 4'h0;
        axi_write(`GWOC_REG_CTRL, 32'h00000221);
        manual_key <= 1'b1;
        n = 0;
        prev = 1'b1;
        repeat (600) begin
            @(posedge aclk);
            if (sync_sub_out === 1'b1 && prev === 1'b0) n++;
            prev = sync_sub_out;
        end
        check(n >= 2, "reference pulses");
        manual_key <= 1'b0;
        wait_en(1'b0, n, p);
        $display("test aux output done");
    endtask

    task automatic summarize;
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            summarize();
        end
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_manual(1'b0, 16'h1000, 1'b0);
        t_manual(1'b1, 16'h4000, 1'b1);
        t_ext();
        t_int();
        t_noise();
        t_remote();
        t_aux();
        summarize();
    end
endmodule

bind gwoc_top gwoc_monitor mon (.*);
